// File: apcr_pkg.sv
// Constants, register map and decode helpers for the control register bank.
package apcr_pkg;

  // ==========================================================================
  // Widths and serial frame layout
  // ==========================================================================
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int IDX_W = 5;
  localparam int NUM_REGS = 19;
  localparam int STATUS_W = 8;
  localparam logic [CNT_W-1:0] HDR_LAST_BIT = 5'h07;
  localparam logic [CNT_W-1:0] DATA_FIRST_BIT = 5'h08;
  localparam logic [CNT_W-1:0] FRAME_LAST_BIT = 5'h0F;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic RW_READ = 1'b1;
  localparam int RW_POS = 6;

  // ==========================================================================
  // Register map: offsets, reset values and writable bits, in table order
  // ==========================================================================
  localparam logic [IDX_W-1:0] IDX_NONE = 5'h13;
  localparam int IDX_CONV = 0;
  localparam int IDX_LGAIN = 1;
  localparam int IDX_RGAIN = 2;
  localparam int IDX_LPLAY = 3;
  localparam int IDX_RPLAY = 4;
  localparam int IDX_STATUS = 13;
  localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09,
    7'h0A, 7'h0C, 7'h10, 7'h11, 7'h12, 7'h14, 7'h15, 7'h17, 7'h20};
  localparam logic [DATA_W-1:0] REG_RST [NUM_REGS] = '{
    8'h00, 8'h05, 8'h05, 8'h08, 8'h08, 8'h00, 8'h00, 8'h22, 8'h09, 8'h00,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [DATA_W-1:0] REG_WMASK [NUM_REGS] = '{
    8'h3F, 8'h1F, 8'h1F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // ==========================================================================
  // Converter power bits and line-in gain selector
  // ==========================================================================
  localparam int BIT_LLI_PWR = 0;
  localparam int BIT_RLI_PWR = 1;
  localparam int BIT_LLO_PWR = 2;
  localparam int BIT_RLO_PWR = 3;
  localparam int BIT_LCONV_PWR = 4;
  localparam int BIT_RCONV_PWR = 5;
  localparam int GAIN_SEL_W = 5;
  localparam logic [GAIN_SEL_W-1:0] GAIN_CODE_TOP = 5'h00;
  localparam logic [GAIN_SEL_W-1:0] GAIN_CODE_LAST = 5'h10;
  localparam logic signed [7:0] GAIN_TOP_DB = 8'sh14;
  localparam logic signed [7:0] GAIN_CODE1_DB = 8'sh0C;
  localparam logic signed [7:0] GAIN_STEP_DB = 8'sh03;
  localparam logic signed [7:0] GAIN_MUTE_DB = 8'shC4;

  // Maps a serial address to a register slot, or IDX_NONE when unmapped.
  function automatic logic [IDX_W-1:0] reg_index(
    input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = IDX_NONE;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == addr) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

endpackage

// File: apcr_serial_slave.sv
// Four-wire serial slave that turns frames into register reads and writes.
`timescale 1ns/10ps

module apcr_serial_slave (
  // Clock, reset and freeze.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial pins, asynchronous to core_clk.
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  // Register side.
  output logic [apcr_pkg::ADDR_W-1:0] frame_addr,
  input wire logic [apcr_pkg::DATA_W-1:0] rd_data,
  output logic wr_stb,
  output logic [apcr_pkg::ADDR_W-1:0] wr_addr,
  output logic [apcr_pkg::DATA_W-1:0] wr_data
);

  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic sel_s1_q, sel_s2_q, sel_s3_q;
  logic sdi_s1_q, sdi_s2_q;
  logic sclk_fall, sclk_rise, sel_active, sel_rise;
  logic [apcr_pkg::CNT_W-1:0] bit_cnt_q;
  logic [apcr_pkg::DATA_W-2:0] shift_in_q;
  logic is_read_q;
  logic [apcr_pkg::DATA_W-1:0] shift_out_q;

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  // Data passes the same two stages as the clock, so sampling stays aligned.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Clock and select reset to the parked-high level, so no false edge follows reset; data resets low.
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sclk_s3_q <= 1'b1;
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else if (clk_en) begin
      sclk_s1_q <= serial_clk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sel_s1_q <= serial_select_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      sdi_s1_q <= serial_data_in;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // Edges are seen only from the second stage onward.
  assign sclk_fall = sclk_s3_q & ~sclk_s2_q;
  assign sclk_rise = ~sclk_s3_q & sclk_s2_q;
  assign sel_active = ~sel_s2_q;
  assign sel_rise = ~sel_s3_q & sel_s2_q;

  // ==========================================================================
  // Input shifting on falling edges
  // ==========================================================================
  // Idle whenever deselected, so an aborted frame never leaks into the next.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
      shift_in_q <= '0;
      is_read_q <= 1'b0;
      frame_addr <= '0;
      wr_stb <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else if (clk_en) begin
      wr_stb <= 1'b0;
      if (!sel_active || sel_rise) begin
        bit_cnt_q <= '0;
        is_read_q <= 1'b0;
      end else if (sclk_fall && bit_cnt_q != apcr_pkg::FRAME_BITS) begin
        // Bits arrive MSB first: direction, address, then data.
        shift_in_q <= {shift_in_q[apcr_pkg::DATA_W-3:0], sdi_s2_q};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == apcr_pkg::HDR_LAST_BIT) begin
          is_read_q <= shift_in_q[apcr_pkg::RW_POS] == apcr_pkg::RW_READ;
          frame_addr <= {shift_in_q[apcr_pkg::RW_POS-1:0], sdi_s2_q};
        end
        if (bit_cnt_q == apcr_pkg::FRAME_LAST_BIT && !is_read_q) begin
          wr_stb <= 1'b1;
          wr_addr <= frame_addr;
          wr_data <= {shift_in_q, sdi_s2_q};
        end
      end
    end
  end

  // ==========================================================================
  // Output shifting on rising edges
  // ==========================================================================
  // The pin is released at every deselect so the host bus can be shared.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out_q <= '0;
      serial_data_out <= 1'b0;
      serial_data_out_en <= 1'b0;
    end else if (clk_en) begin
      if (!sel_active || sel_rise) begin
        serial_data_out <= 1'b0;
        serial_data_out_en <= 1'b0;
      end else if (sclk_rise && is_read_q) begin
        if (bit_cnt_q == apcr_pkg::DATA_FIRST_BIT) begin
          serial_data_out <= rd_data[apcr_pkg::DATA_W-1];
          shift_out_q <= {rd_data[apcr_pkg::DATA_W-2:0], 1'b0};
          serial_data_out_en <= 1'b1;
        end else if (bit_cnt_q > apcr_pkg::DATA_FIRST_BIT &&
                     bit_cnt_q != apcr_pkg::FRAME_BITS) begin
          serial_data_out <= shift_out_q[apcr_pkg::DATA_W-1];
          shift_out_q <= {shift_out_q[apcr_pkg::DATA_W-2:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================================
  // Checks on the serial engine
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_idle_no_drive: assert property (
    clk_en && !sel_active |=> !serial_data_out_en)
    else $error("Data output driven while deselected.");

  a_read_first_bit: assert property (
    $rose(serial_data_out_en) |-> serial_data_out == $past(rd_data[7]))
    else $error("First read bit is not the register MSB.");

  a_out_on_rise: assert property (
    serial_data_out_en && $changed(serial_data_out) |-> $past(sclk_rise))
    else $error("Output bit changed without a rising serial edge.");

  a_write_after_16: assert property (
    wr_stb |-> bit_cnt_q == apcr_pkg::FRAME_BITS && !is_read_q)
    else $error("Write strobe outside the end of a write frame.");

endmodule

// File: apcr_control_regs.sv
// Control register bank of the audio converter and power block.
`timescale 1ns/10ps

// Summary of operation
// - Byte registers at map offsets; status is read-only.
// - Converter bit0 powers left line-in amplifier.
// - Converter bit1 powers right line-in amplifier.
// - Converter bits2,3 power left/right line-out drivers.
// - Converter bits4,5 power left/right converter channels.
// - Left gain: five-bit selector, resets 00101, reserved zero.
// - Selector: +20, +12, then -3 dB steps; mute.
// - Right gain register mirrors left gain layout.
// - Printed reset values; 0x07/0x08/0x0A reset 0x22/0x09/0x02, gains 0x01-0x04 as below, all others zero.
// - Master playback gains at 0x03/0x04, reset 0x08.
// - Frame: direction bit, 7-bit address, 8 data bits.
// - Select low enables; deselect idles, output released.
// - Sample input on falling, shift output on rising.
module apcr_control_regs (
  // Clock, reset and freeze.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial link pins.
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  // Supply and short status from the analog side, asynchronous.
  input wire logic [apcr_pkg::STATUS_W-1:0] status_in,
  // Power controls.
  output logic left_linein_amp_power,
  output logic right_linein_amp_power,
  output logic left_lineout_drv_power,
  output logic right_lineout_drv_power,
  output logic left_converter_power,
  output logic right_converter_power,
  // Line-in gain.
  output logic [apcr_pkg::GAIN_SEL_W-1:0] left_input_gain_sel,
  output logic [apcr_pkg::GAIN_SEL_W-1:0] right_input_gain_sel,
  output logic signed [7:0] left_input_gain_db,
  output logic signed [7:0] right_input_gain_db,
  output logic left_input_mute,
  output logic right_input_mute,
  // Master playback gain.
  output logic [apcr_pkg::DATA_W-1:0] left_playback_gain,
  output logic [apcr_pkg::DATA_W-1:0] right_playback_gain
);

  logic [apcr_pkg::DATA_W-1:0] reg_q [apcr_pkg::NUM_REGS];
  logic [apcr_pkg::STATUS_W-1:0] status_s1_q, status_s2_q;
  logic [apcr_pkg::ADDR_W-1:0] frame_addr;
  logic [apcr_pkg::DATA_W-1:0] rd_data;
  logic wr_stb;
  logic [apcr_pkg::ADDR_W-1:0] wr_addr;
  logic [apcr_pkg::DATA_W-1:0] wr_data;
  logic [apcr_pkg::IDX_W-1:0] wr_idx, rd_idx;
  logic started_q;
  logic all_at_reset;

  // ==========================================================================
  // Line-in gain decode
  // ==========================================================================
  // Returns {mute, gain in dB}; deep codes report the floor as mute.
  function automatic logic [8:0] gain_decode(
    input logic [apcr_pkg::GAIN_SEL_W-1:0] code);
    logic signed [7:0] db;
    logic mute;
    mute = 1'b0;
    if (code == apcr_pkg::GAIN_CODE_TOP) begin
      db = apcr_pkg::GAIN_TOP_DB;
    end else if (code <= apcr_pkg::GAIN_CODE_LAST) begin
      db = 8'(int'(apcr_pkg::GAIN_CODE1_DB) -
              int'(apcr_pkg::GAIN_STEP_DB) * (int'(code) - 1));
    end else begin
      db = apcr_pkg::GAIN_MUTE_DB;
      mute = 1'b1;
    end
    return {mute, db};
  endfunction

  // ==========================================================================
  // Serial engine
  // ==========================================================================
  apcr_serial_slave u_serial (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .serial_clk(serial_clk),
    .serial_select_n(serial_select_n),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en),
    .frame_addr(frame_addr),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // ==========================================================================
  // Status capture
  // ==========================================================================
  // The analog flags change at any time, so they are synchronised first.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_s1_q <= '0;
      status_s2_q <= '0;
    end else if (clk_en) begin
      status_s1_q <= status_in;
      status_s2_q <= status_s1_q;
    end
  end

  // ==========================================================================
  // Register array
  // ==========================================================================
  // Address decode is shared by the write and read paths.
  assign wr_idx = apcr_pkg::reg_index(wr_addr);
  assign rd_idx = apcr_pkg::reg_index(frame_addr);

  // Reserved bits are masked on write, so they always read back as zero.
  for (genvar i = 0; i < apcr_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        reg_q[i] <= apcr_pkg::REG_RST[i];
      end else if (clk_en) begin
        if (i == apcr_pkg::IDX_STATUS) begin
          reg_q[i] <= status_s2_q;
        end else if (wr_stb && wr_idx == apcr_pkg::IDX_W'(i)) begin
          reg_q[i] <= wr_data & apcr_pkg::REG_WMASK[i];
        end
      end
    end
  end

  // Unmapped offsets read as zero.
  always_comb begin
    rd_data = '0;
    if (rd_idx != apcr_pkg::IDX_NONE) begin
      rd_data = reg_q[rd_idx];
    end
  end

  // ==========================================================================
  // Registered controls towards the analog side
  // ==========================================================================
  // One flop stage keeps every control glitch-free towards the analog side.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_linein_amp_power <= 1'b0;
      right_linein_amp_power <= 1'b0;
      left_lineout_drv_power <= 1'b0;
      right_lineout_drv_power <= 1'b0;
      left_converter_power <= 1'b0;
      right_converter_power <= 1'b0;
    end else if (clk_en) begin
      left_linein_amp_power <=
        reg_q[apcr_pkg::IDX_CONV][apcr_pkg::BIT_LLI_PWR];
      right_linein_amp_power <=
        reg_q[apcr_pkg::IDX_CONV][apcr_pkg::BIT_RLI_PWR];
      left_lineout_drv_power <=
        reg_q[apcr_pkg::IDX_CONV][apcr_pkg::BIT_LLO_PWR];
      right_lineout_drv_power <=
        reg_q[apcr_pkg::IDX_CONV][apcr_pkg::BIT_RLO_PWR];
      left_converter_power <=
        reg_q[apcr_pkg::IDX_CONV][apcr_pkg::BIT_LCONV_PWR];
      right_converter_power <=
        reg_q[apcr_pkg::IDX_CONV][apcr_pkg::BIT_RCONV_PWR];
    end
  end

  // Gain selectors, their decoded value, and the playback gains.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_input_gain_sel <= apcr_pkg::REG_RST[apcr_pkg::IDX_LGAIN][4:0];
      right_input_gain_sel <= apcr_pkg::REG_RST[apcr_pkg::IDX_RGAIN][4:0];
      left_input_gain_db <= '0;
      right_input_gain_db <= '0;
      left_input_mute <= 1'b0;
      right_input_mute <= 1'b0;
      left_playback_gain <= apcr_pkg::REG_RST[apcr_pkg::IDX_LPLAY];
      right_playback_gain <= apcr_pkg::REG_RST[apcr_pkg::IDX_RPLAY];
    end else if (clk_en) begin
      left_input_gain_sel <= reg_q[apcr_pkg::IDX_LGAIN][4:0];
      right_input_gain_sel <= reg_q[apcr_pkg::IDX_RGAIN][4:0];
      {left_input_mute, left_input_gain_db} <=
        gain_decode(reg_q[apcr_pkg::IDX_LGAIN][4:0]);
      {right_input_mute, right_input_gain_db} <=
        gain_decode(reg_q[apcr_pkg::IDX_RGAIN][4:0]);
      left_playback_gain <= reg_q[apcr_pkg::IDX_LPLAY];
      right_playback_gain <= reg_q[apcr_pkg::IDX_RPLAY];
    end
  end

  // ==========================================================================
  // Checks on the register bank
  // ==========================================================================
  // Marks the first clock edge after reset release, for the reset check.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  always_comb begin
    all_at_reset = 1'b1;
    for (int i = 0; i < apcr_pkg::NUM_REGS; i++) begin
      if (reg_q[i] != apcr_pkg::REG_RST[i]) begin
        all_at_reset = 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_conv_write;
    wr_stb && clk_en && wr_idx == apcr_pkg::IDX_CONV ##1 clk_en;
  endsequence

  a_reset_values: assert property (
    !started_q |-> all_at_reset)
    else $error("Register not at its reset value after reset.");

  a_status_readonly: assert property (
    clk_en |=> reg_q[apcr_pkg::IDX_STATUS] == $past(status_s2_q))
    else $error("Status register does not follow the status inputs.");

  a_left_in_power: assert property (
    s_conv_write |=> left_linein_amp_power == $past(wr_data[0], 2))
    else $error("Left line-in power does not follow bit 0.");

  a_right_in_power: assert property (
    s_conv_write |=> right_linein_amp_power == $past(wr_data[1], 2))
    else $error("Right line-in power does not follow bit 1.");

  a_out_conv_power: assert property (
    s_conv_write |=> right_converter_power == $past(wr_data[5], 2) &&
      left_lineout_drv_power == $past(wr_data[2], 2))
    else $error("Driver or converter power does not follow its bit.");

  a_gain_reserved: assert property (
    reg_q[apcr_pkg::IDX_LGAIN][7:5] == 3'h0 &&
    reg_q[apcr_pkg::IDX_RGAIN][7:5] == 3'h0)
    else $error("Reserved line-in gain bits are not zero.");

  a_gain_decode_top: assert property (
    clk_en && reg_q[apcr_pkg::IDX_LGAIN][4:0] == 5'h00 |=>
      left_input_gain_db == 8'sh14 && !left_input_mute)
    else $error("Code zero does not decode to +20 dB.");

  a_gain_decode_last: assert property (
    clk_en && reg_q[apcr_pkg::IDX_RGAIN][4:0] == 5'h10 |=>
      right_input_gain_db == 8'shDF && !right_input_mute)
    else $error("Code 16 does not decode to -33 dB.");

  a_gain_mute: assert property (
    clk_en && reg_q[apcr_pkg::IDX_LGAIN][4:0] > 5'h10 |=> left_input_mute)
    else $error("Deep code does not report mute.");

  a_playback_write: assert property (
    wr_stb && clk_en && wr_idx == apcr_pkg::IDX_RPLAY |=>
      reg_q[apcr_pkg::IDX_RPLAY] == ($past(wr_data) & 8'h3F))
    else $error("Right playback gain write not stored.");

  a_unmapped_zero: assert property (
    rd_idx == apcr_pkg::IDX_NONE |-> rd_data == 8'h00)
    else $error("Unmapped offset does not read as zero.");

  a_drv_power: assert property (
    s_conv_write |=> right_lineout_drv_power == $past(wr_data[3], 2) &&
      left_converter_power == $past(wr_data[4], 2))
    else $error("Right driver or left converter power does not follow.");

  a_gain_sel_copy: assert property (
    clk_en |=>
      left_input_gain_sel == $past(reg_q[apcr_pkg::IDX_LGAIN][4:0]) &&
      right_input_gain_sel == $past(reg_q[apcr_pkg::IDX_RGAIN][4:0]))
    else $error("Line-in gain selector does not follow its register.");

  a_right_mute: assert property (
    clk_en && reg_q[apcr_pkg::IDX_RGAIN][4:0] > 5'h10 |=>
      right_input_mute)
    else $error("Deep right code does not report mute.");

  a_reset_outputs: assert property (
    !started_q |-> left_input_gain_sel == 5'h05 &&
      right_input_gain_sel == 5'h05 && left_playback_gain == 8'h08)
    else $error("Outputs not at their reset values after reset.");

  a_left_playback: assert property (
    wr_stb && clk_en && wr_idx == apcr_pkg::IDX_LPLAY |=>
      reg_q[apcr_pkg::IDX_LPLAY] == ($past(wr_data) & 8'h3F))
    else $error("Left playback gain write not stored.");

  // A write to a hole in the map must leave the control and left gain registers alone.
  a_unmapped_write: assert property (
    wr_stb && clk_en && wr_idx == apcr_pkg::IDX_NONE |=>
      $stable(reg_q[apcr_pkg::IDX_CONV]) &&
      $stable(reg_q[apcr_pkg::IDX_LGAIN]))
    else $error("Unmapped write changed a register.");

endmodule

// File: apcr_host_model.sv
// Serial host model that frames reads and writes for the register bank.
`timescale 1ns/10ps

module apcr_host_model (
  // Clock.
  input wire logic core_clk,
  // Serial pins.
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_data_in,
  input wire logic serial_data_wire
);
  // ==========================================================================
  // Frame engine
  // ==========================================================================
  // The link clock parks high and stands still between frames.
  // The audio master clock lies outside this bench; a real host keeps it
  // running through every converter write.
  initial begin
    serial_clk = 1'b1;
    serial_select_n = 1'b1;
    serial_data_in = 1'b0;
  end

  // Waits a number of core clock edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Sends nbits of a frame MSB first; a short count aborts the frame.
  task automatic xfer(input logic [15:0] frame, input int nbits,
                      output logic [7:0] rdat);
    rdat = 8'h00;
    cyc(1);
    serial_select_n <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      // Data moves with the rising edge; one bit lasts 8 cycles, 400 ns.
      serial_data_in <= frame[i];
      cyc(4);
      // Data out moved on the last rise, so it is settled before this fall.
      if (i < 8) rdat[i] = serial_data_wire;
      serial_clk <= 1'b0;
      cyc(4);
      serial_clk <= 1'b1;
    end
    cyc(4);
    serial_select_n <= 1'b1;
    // A released line must not keep its last value.
    serial_data_in <= ~serial_data_in;
    cyc(6);
  endtask
endmodule

// File: apcr_control_regs_tb.sv
// Self-checking testbench for the control register bank.
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  n_fail++; $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module apcr_control_regs_tb;
  logic core_clk, rst_n, clk_en, serial_data_out, serial_data_out_en;
  logic serial_clk, serial_select_n, serial_data_in;
  logic lli, rli, llo, rlo, lcv, rcv, lmute, rmute;
  logic [4:0] lsel, rsel;
  logic signed [7:0] ldb, rdb;
  logic [7:0] status_in, lplay, rplay, rd;
  logic [6:0] unm [4] = '{7'h0B, 7'h13, 7'h16, 7'h7F};
  int n_fail, checks_done, cycles;
  wire serial_data_wire = serial_data_out_en ? serial_data_out : 1'bz;

  apcr_control_regs dut (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en), .status_in(status_in),
    .left_linein_amp_power(lli), .right_linein_amp_power(rli),
    .left_lineout_drv_power(llo), .right_lineout_drv_power(rlo),
    .left_converter_power(lcv), .right_converter_power(rcv),
    .left_input_gain_sel(lsel), .right_input_gain_sel(rsel),
    .left_input_gain_db(ldb), .right_input_gain_db(rdb),
    .left_input_mute(lmute), .right_input_mute(rmute),
    .left_playback_gain(lplay), .right_playback_gain(rplay));

  apcr_host_model host (.core_clk(core_clk), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_data_wire(serial_data_wire));

  // ==========================================================================
  // Clock, timeout and helpers
  // ==========================================================================
  // Free-running 20 MHz core clock.
  always #25 core_clk = ~core_clk;

  // About 19k cycles are expected; the ceiling leaves ample margin.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.xfer({1'b0, a, d}, 16, dummy);
  endtask

  task automatic rdreg(input logic [6:0] a, output logic [7:0] d);
    host.xfer({1'b1, a, 8'h00}, 16, d);
  endtask

  // Expected line-in gain in dB for a selector code.
  function automatic logic signed [7:0] exp_db(input logic [4:0] c);
    int v;
    v = (c == 5'h00) ? 20 : (c > 5'h10) ? -60 : 15 - 3 * int'(c);
    return 8'(v);
  endfunction

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  // Main sequence of register accesses and output checks.
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    status_in = 8'h00;
    repeat (3) @(posedge core_clk);
    `CHK("gain sel", 5'h05, lsel)
    `CHK("playback", 8'h08, rplay)
    `CHK("power", 6'h00, {rcv, lcv, rlo, llo, rli, lli})
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < apcr_pkg::NUM_REGS; i++) begin
      rdreg(apcr_pkg::REG_ADDR[i], rd);
      `CHK("reset value", apcr_pkg::REG_RST[i], rd)
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      wr(7'h00, 8'hC0 | (8'h01 << i));
      `CHK("power", 6'h01 << i, {rcv, lcv, rlo, llo, rli, lli})
    end
    rdreg(7'h00, rd);
    `CHK("control readback", 8'h20, rd)
    $display("test power bits done");
    for (int c = 0; c < 32; c++) begin
      wr(7'h01, 8'hE0 | 8'(c));
      wr(7'h02, 8'(31 - c));
      rdreg(7'h01, rd);
      `CHK("left gain reg", 8'(c), rd)
      `CHK("left sel", 5'(c), lsel)
      `CHK("left db", exp_db(5'(c)), ldb)
      `CHK("left mute", c > 16, lmute)
      `CHK("right sel", 5'(31 - c), rsel)
      `CHK("right db", exp_db(5'(31 - c)), rdb)
      `CHK("right mute", c < 15, rmute)
    end
    $display("test line-in gain done");
    status_in <= 8'hA5;
    wr(7'h11, 8'h5A);
    rdreg(7'h11, rd);
    `CHK("status", 8'hA5, rd)
    foreach (unm[i]) begin
      wr(unm[i], 8'hFF);
      rdreg(unm[i], rd);
      `CHK("unmapped", 8'h00, rd)
    end
    $display("test status and unmapped done");
    wr(7'h03, 8'hFF);
    wr(7'h04, 8'h21);
    `CHK("left playback", 8'h3F, lplay)
    `CHK("right playback", 8'h21, rplay)
    $display("test playback gain done");
    host.xfer({1'b0, 7'h00, 8'h3F}, 10, rd);
    `CHK("power abort", 6'h20, {rcv, lcv, rlo, llo, rli, lli})
    `CHK("idle enable", 1'b0, serial_data_out_en)
    wr(7'h00, 8'h15);
    `CHK("after abort", 6'h15, {rcv, lcv, rlo, llo, rli, lli})
    $display("test aborted frame done");
    clk_en <= 1'b0;
    wr(7'h01, 8'h0A);
    clk_en <= 1'b1;
    `CHK("frozen sel", 5'h1F, lsel)
    rst_n <= 1'b0;
    @(posedge core_clk);
    `CHK("reset power", 6'h00, {rcv, lcv, rlo, llo, rli, lli})
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdreg(7'h00, rd);
    `CHK("control after reset", 8'h00, rd)
    rdreg(7'h01, rd);
    `CHK("gain after reset", 8'h05, rd)
    $display("test freeze and reset done");
    give_verdict();
  end
endmodule
